// ===== rtl/fcs_pkg.sv
// flash command sequencer: shared constants, command codes and carriers
// assumes a 50 MHz system clock and an apb master reaching the flash window
package fcs_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROG_TIME_NS = 60000;
  localparam int PROG_CYC = (PROG_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                            PROG_TIME_NS / CLK_PERIOD_NS;
  localparam longint SECT_ERASE_TIME_MS = 75;
  localparam longint CHIP_ERASE_TIME_MS = 300;
  localparam int SECT_ERASE_CYC = int'(SECT_ERASE_TIME_MS * 64'd1000000 / CLK_PERIOD_NS);
  localparam int CHIP_ERASE_CYC = int'(CHIP_ERASE_TIME_MS * 64'd1000000 / CLK_PERIOD_NS);

  // ==========================================================
  // command offsets (flash byte offsets, apb word index)
  localparam int OFS_W = 12;
  localparam logic [11:0] UNLOCK1_OFS = 12'hAAA;
  localparam logic [11:0] UNLOCK2_OFS = 12'h554;
  localparam logic [11:0] PROT_OFS = 12'h77E;
  localparam logic [11:0] ID_VENDOR_OFS = 12'h000;
  localparam logic [11:0] ID_MACRO_OFS = 12'h002;
  localparam logic [11:0] ID_SIZE_OFS = 12'h004;
  localparam int SECTOR_LSB = 13;

  // ==========================================================
  // command data bytes
  localparam logic [7:0] DAT_UNLOCK1 = 8'hAA;
  localparam logic [7:0] DAT_UNLOCK2 = 8'h55;
  localparam logic [7:0] DAT_PROG = 8'hA0;
  localparam logic [7:0] DAT_ERASE = 8'h80;
  localparam logic [7:0] DAT_SECT = 8'h30;
  localparam logic [7:0] DAT_CHIP = 8'h10;
  localparam logic [7:0] DAT_ID_ENTRY = 8'h90;
  localparam logic [7:0] DAT_ID_EXIT = 8'hF0;
  localparam logic [7:0] DAT_PROT = 8'hA5;

  // ==========================================================
  // status flags and values
  localparam int TOGGLE_BIT = 6;
  localparam int POLL_BIT = 7;
  localparam logic [7:0] PROT_NONE = 8'hFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [15:0] ID_BLANK = 16'h0000;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_PROG = 3'b001,
    CMD_SECT = 3'b010,
    CMD_CHIP = 3'b011,
    CMD_ID_ENTRY = 3'b100,
    CMD_ID_EXIT = 3'b101,
    CMD_PROT = 3'b110
  } fcs_cmd_kind_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_U1 = 3'b001,
    SEQ_U2 = 3'b010,
    SEQ_ERS = 3'b011,
    SEQ_ERS_U1 = 3'b100,
    SEQ_ERS_U2 = 3'b101,
    SEQ_PROG = 3'b110,
    SEQ_PROT = 3'b111
  } fcs_seq_t;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PROG = 2'b01,
    OP_ERASE = 2'b10,
    OP_PROT = 2'b11
  } fcs_op_t;

  typedef struct packed {
    logic stb;
    logic [11:0] ofs;
    logic [15:0] data;
  } fcs_wr_t;

  typedef struct packed {
    fcs_cmd_kind_t kind;
    logic [15:0] data;
  } fcs_cmd_t;

endpackage : fcs_pkg

// ===== rtl/fcs_cmd_decode.sv
// flash command sequencer: unlock sequence decoder
// assumes write strobes arrive only while no auto operation runs
module fcs_cmd_decode
  import fcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire fcs_wr_t wr,
  output fcs_cmd_t cmd
);

  typedef struct packed {
    fcs_seq_t seq;
    fcs_cmd_t cmd;
  } dec_state_t;

  dec_state_t s_ff;
  dec_state_t nxt_s;

  // ==========================================================
  // sequence walk; a wrong cycle drops back to idle
  always_comb begin
    nxt_s = s_ff;
    nxt_s.cmd.kind = CMD_NONE;
    if (rst) begin
      nxt_s.seq = SEQ_IDLE;
      nxt_s.cmd = '{kind: CMD_NONE, data: 16'h0000};
    end else if (wr.stb) begin
      nxt_s.seq = SEQ_IDLE;
      nxt_s.cmd.data = wr.data;
      case (s_ff.seq)
        SEQ_IDLE: begin
          if (wr.ofs == UNLOCK1_OFS && wr.data[7:0] == DAT_UNLOCK1) begin
            nxt_s.seq = SEQ_U1;
          end else if (wr.data[7:0] == DAT_ID_EXIT) begin
            nxt_s.cmd.kind = CMD_ID_EXIT;
          end
        end
        SEQ_U1: begin
          if (wr.ofs == UNLOCK2_OFS && wr.data[7:0] == DAT_UNLOCK2) begin
            nxt_s.seq = SEQ_U2;
          end
        end
        SEQ_U2: begin
          if (wr.ofs == UNLOCK1_OFS) begin
            case (wr.data[7:0])
              DAT_PROG: nxt_s.seq = SEQ_PROG;
              DAT_ERASE: nxt_s.seq = SEQ_ERS;
              DAT_PROT: nxt_s.seq = SEQ_PROT;
              DAT_ID_ENTRY: nxt_s.cmd.kind = CMD_ID_ENTRY;
              DAT_ID_EXIT: nxt_s.cmd.kind = CMD_ID_EXIT;
              default: nxt_s.seq = SEQ_IDLE;
            endcase
          end
        end
        SEQ_ERS: begin
          if (wr.ofs == UNLOCK1_OFS && wr.data[7:0] == DAT_UNLOCK1) begin
            nxt_s.seq = SEQ_ERS_U1;
          end
        end
        SEQ_ERS_U1: begin
          if (wr.ofs == UNLOCK2_OFS && wr.data[7:0] == DAT_UNLOCK2) begin
            nxt_s.seq = SEQ_ERS_U2;
          end
        end
        SEQ_ERS_U2: begin
          if (wr.data[7:0] == DAT_SECT) begin
            nxt_s.cmd.kind = CMD_SECT;
          end else if (wr.ofs == UNLOCK1_OFS && wr.data[7:0] == DAT_CHIP) begin
            nxt_s.cmd.kind = CMD_CHIP;
          end
        end
        SEQ_PROG: nxt_s.cmd.kind = CMD_PROG;
        SEQ_PROT: begin
          if (wr.ofs == PROT_OFS) begin
            nxt_s.cmd.kind = CMD_PROT;
          end
        end
        default: nxt_s.seq = SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    s_ff <= nxt_s;
  end

  assign cmd = s_ff.cmd;

endmodule : fcs_cmd_decode

// ===== rtl/fcs_op_timer.sv
// flash command sequencer: auto operation duration counter
// assumes load is a one-cycle pulse and load_val is at least one
module fcs_op_timer #(
  parameter int CNT_W = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic done;
  } tmr_state_t;

  tmr_state_t s_ff;
  tmr_state_t nxt_s;

  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
    $error("fcs_op_timer: CNT_W out of range");
  end

  // ==========================================================
  // count down; done pulses in the cycle after the last count
  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (rst) begin
      nxt_s = '0;
    end else if (load) begin
      nxt_s.cnt = load_val;
    end else if (s_ff.cnt != '0) begin
      nxt_s.cnt = s_ff.cnt - 1'b1;
      nxt_s.done = (s_ff.cnt == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk_sys) begin
    s_ff <= nxt_s;
  end

  assign busy = (s_ff.cnt != '0);
  assign done = s_ff.done;

endmodule : fcs_op_timer

// ===== rtl/fcs_flash_seq.sv
// flash command sequencer: apb slave over the flash array with auto operations
// assumes an apb master on clk_sys and a combinational boot rom outside the block
//
// Local design decisions: the register addresses and the APB interface to the registers.
module fcs_flash_seq
  import fcs_pkg::*;
#(
  parameter int ADDR_W = 14,
  parameter int SECT_CYC = SECT_ERASE_CYC,
  parameter int CHIP_CYC = CHIP_ERASE_CYC,
  parameter logic [7:0] VENDOR_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] MACRO_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] SIZE_CODE = 8'h0E // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic boot_mode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W+2:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ADDR_W-1:0] boot_rom_addr,
  input wire logic [15:0] boot_rom_rdata
);

  localparam int WORD_W = ADDR_W - 1;
  localparam int WORDS = 1 << WORD_W;
  localparam int SECT_WORDS = 1 << (SECTOR_LSB - 1);

  // ==========================================================
  // elaboration checks
  if (ADDR_W < SECTOR_LSB + 1 || ADDR_W > 24) begin : g_bad_addr_w
    $error("fcs_flash_seq: ADDR_W must be 14 to 24");
  end
  // the sweep must end before the timer closes the operation
  if (SECT_CYC <= SECT_WORDS) begin : g_bad_sect_cyc
    $error("fcs_flash_seq: sector erase time shorter than its sweep");
  end
  if (CHIP_CYC <= WORDS) begin : g_bad_chip_cyc
    $error("fcs_flash_seq: chip erase time shorter than the array sweep");
  end

  typedef struct packed {
    fcs_op_t op;
    logic boot;
    logic id_mode;
    logic toggle;
    logic chip;
    logic [ADDR_W-1:0] wr_idx;
    logic [ADDR_W-1:0] op_idx;
    logic [15:0] op_data;
    logic [WORD_W-1:0] ers_ptr;
    logic [WORD_W:0] ers_left;
    logic [7:0] protect;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [ADDR_W-1:0] rom_addr;
  } seq_state_t;

  seq_state_t s_ff;
  seq_state_t nxt_s;
  logic [15:0] mem [WORDS];
  logic mem_we;
  logic [WORD_W-1:0] mem_wa;
  logic [15:0] mem_wd;
  fcs_wr_t wr;
  fcs_cmd_t cmd;
  logic tmr_load;
  logic [31:0] tmr_val;
  logic tmr_busy;
  logic tmr_done;

  // ==========================================================
  // identification read decode
  function automatic logic [15:0] id_read(input logic [11:0] ofs, input logic [7:0] prot);
    logic [15:0] val;
    val = ID_BLANK;
    if (ofs == ID_VENDOR_OFS) begin
      val = {8'h00, VENDOR_CODE};
    end else if (ofs == ID_MACRO_OFS) begin
      val = {8'h00, MACRO_CODE};
    end else if (ofs == ID_SIZE_OFS) begin
      val = {8'h00, SIZE_CODE};
    end else if (ofs == PROT_OFS) begin
      val = {8'h00, prot};
    end
    return val;
  endfunction : id_read

  // ==========================================================
  // region decode; in boot mode the rom owns the lower half of the window
  function automatic logic in_flash_region(input logic [ADDR_W:0] idx, input logic boot);
    return (boot == idx[ADDR_W]);
  endfunction : in_flash_region

  // ==========================================================
  // status word while an auto operation runs; other bits read zero
  function automatic logic [15:0] status_word(input fcs_op_t op, input logic tgl,
    input logic [15:0] pdata);
    logic [15:0] val;
    val = 16'h0000;
    val[TOGGLE_BIT] = tgl;
    if (op == OP_PROG) begin
      val[POLL_BIT] = ~pdata[POLL_BIT];
    end
    return val;
  endfunction : status_word

  // ==========================================================
  // submodules
  fcs_cmd_decode u_dec (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr(wr),
    .cmd(cmd)
  );

  fcs_op_timer #(
    .CNT_W(32)
  ) u_tmr (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ==========================================================
  // main state
  always_comb begin
    logic [ADDR_W:0] idx;
    logic [ADDR_W-1:0] fidx;
    logic in_flash;
    logic rom_hit;
    logic busy;
    logic [15:0] word;
    logic [15:0] rd;
    idx = paddr[ADDR_W+2:2];
    fidx = idx[ADDR_W-1:0];
    in_flash = in_flash_region(idx, s_ff.boot);
    rom_hit = s_ff.boot && !in_flash;
    busy = (s_ff.op != OP_READ);
    word = mem[fidx[ADDR_W-1:1]];
    rd = 16'h0000;
    nxt_s = s_ff;
    wr = '{stb: 1'b0, ofs: fidx[OFS_W-1:0], data: pwdata[15:0]};
    tmr_load = 1'b0;
    tmr_val = 32'd0;
    mem_we = 1'b0;
    mem_wa = s_ff.ers_ptr;
    mem_wd = ERASED_WORD;
    if (rst) begin
      nxt_s = '0;
      nxt_s.op = OP_READ;
      nxt_s.boot = boot_mode;
      nxt_s.protect = PROT_NONE;
    end else begin
      // setup phase drives the boot rom address; it is read one cycle later
      if (psel && !penable) begin
        nxt_s.rom_addr = idx[ADDR_W-1:0];
      end
      // access: answer one cycle after penable rises
      if (psel && penable && !s_ff.pready) begin
        nxt_s.pready = 1'b1;
        nxt_s.pslverr = 1'b0;
        if (rom_hit) begin
          rd = boot_rom_rdata;
        end else if (!in_flash) begin
          nxt_s.pslverr = 1'b1;
        end else if (busy) begin
          rd = status_word(s_ff.op, s_ff.toggle, s_ff.op_data);
        end else if (s_ff.id_mode) begin
          rd = id_read(fidx[OFS_W-1:0], s_ff.protect);
        end else if (fidx[0]) begin
          rd = {8'h00, word[15:8]};
        end else begin
          rd = word;
        end
        // writes are answered too, but the last read data stays on the bus
        if (!pwrite) begin
          nxt_s.prdata = {16'h0000, rd};
        end
      end
      // completion edge: writes land and status reads advance the toggle
      if (psel && penable && s_ff.pready) begin
        nxt_s.pready = 1'b0;
        nxt_s.pslverr = 1'b0;
        if (in_flash && !pwrite && busy) begin
          nxt_s.toggle = ~s_ff.toggle;
        end
        // new commands are refused while an operation runs
        // only the low lane strobe admits commands; program data comes from the low two lanes
        if (in_flash && pwrite && !busy && !tmr_busy && pstrb[0]) begin
          wr.stb = 1'b1;
          nxt_s.wr_idx = fidx;
        end
      end
      // launch a decoded command
      case (cmd.kind)
        CMD_PROG: begin
          if (!s_ff.wr_idx[0]) begin
            nxt_s.op = OP_PROG;
            nxt_s.op_idx = s_ff.wr_idx;
            nxt_s.op_data = cmd.data;
            nxt_s.toggle = 1'b1;
            tmr_load = 1'b1;
            tmr_val = PROG_CYC;
          end
        end
        CMD_SECT: begin
          nxt_s.op = OP_ERASE;
          nxt_s.chip = 1'b0;
          nxt_s.toggle = 1'b1;
          nxt_s.ers_ptr = {s_ff.wr_idx[ADDR_W-1:SECTOR_LSB], {(SECTOR_LSB-1){1'b0}}};
          nxt_s.ers_left = (WORD_W+1)'(SECT_WORDS);
          tmr_load = 1'b1;
          tmr_val = SECT_CYC;
        end
        CMD_CHIP: begin
          nxt_s.op = OP_ERASE;
          nxt_s.chip = 1'b1;
          nxt_s.toggle = 1'b1;
          nxt_s.ers_ptr = '0;
          nxt_s.ers_left = (WORD_W+1)'(WORDS);
          tmr_load = 1'b1;
          tmr_val = CHIP_CYC;
        end
        CMD_PROT: begin
          nxt_s.op = OP_PROT;
          nxt_s.op_data = cmd.data;
          nxt_s.toggle = 1'b1;
          tmr_load = 1'b1;
          tmr_val = PROG_CYC;
        end
        CMD_ID_ENTRY: nxt_s.id_mode = 1'b1;
        CMD_ID_EXIT: nxt_s.id_mode = 1'b0;
        default: nxt_s.id_mode = s_ff.id_mode;
      endcase
      // erase sweep clears one word per cycle and ends before the erase time
      if (s_ff.op == OP_ERASE && s_ff.ers_left != '0) begin
        mem_we = 1'b1;
        nxt_s.ers_ptr = s_ff.ers_ptr + 1'b1;
        nxt_s.ers_left = s_ff.ers_left - 1'b1;
      end
      // finish: cells take their value, reads return to the array
      if (tmr_done && !tmr_load) begin
        nxt_s.op = OP_READ;
        if (s_ff.op == OP_PROG) begin
          mem_we = 1'b1;
          mem_wa = s_ff.op_idx[ADDR_W-1:1];
          // programming only clears bits; ones need an erase first
          mem_wd = mem[s_ff.op_idx[ADDR_W-1:1]] & s_ff.op_data;
        end else if (s_ff.op == OP_PROT) begin
          nxt_s.protect = s_ff.op_data[7:0];
        end else if (s_ff.op == OP_ERASE && s_ff.chip) begin
          nxt_s.protect = PROT_NONE;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    s_ff <= nxt_s;
  end

  // ==========================================================
  // array has no reset; its content survives like real cells
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign boot_rom_addr = s_ff.rom_addr;

endmodule : fcs_flash_seq

// ===== sim/fcs_flash_seq_props.sv
// apb-side checker for the flash sequencer
// assumes it is bound onto fcs_flash_seq and sees only its ports
module fcs_flash_seq_props #(
  parameter int ADDR_W = 14
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic boot_mode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W+2:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ADDR_W-1:0] boot_rom_addr,
  input wire logic [15:0] boot_rom_rdata
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ans_lat_a: assert property (psel && penable && !pready |=> pready)
    else $error("answer not one cycle after access");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  setup_idle_a: assert property (psel && !penable |-> !pready)
    else $error("pready in setup phase");
  upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  err_map_a: assert property (pready |-> pslverr == (!boot_mode && paddr[ADDR_W+2]))
    else $error("error flag does not match map");
  rom_addr_a: assert property (psel && !penable |=> boot_rom_addr == $past(paddr[ADDR_W+1:2]))
    else $error("rom address not captured");
  rom_data_a: assert property (boot_mode && psel && penable && !pready && !pwrite &&
    !paddr[ADDR_W+2] && !paddr[2] |=> prdata[15:0] == $past(boot_rom_rdata))
    else $error("rom data not returned");
  rd_hold_a: assert property (!(pready && !pwrite) |-> $stable(prdata))
    else $error("read data moved without a read");
  cover property (pready && pslverr);
  cover property (pready && !pwrite && prdata[6]);
  cover property (boot_mode && pready && !pwrite);
endmodule : fcs_flash_seq_props

bind fcs_flash_seq fcs_flash_seq_props #(.ADDR_W(ADDR_W)) fcs_flash_seq_props_inst (
  .clk_sys(clk_sys), .rst(rst), .boot_mode(boot_mode), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .boot_rom_addr(boot_rom_addr), .boot_rom_rdata(boot_rom_rdata));

// ===== sim/fcs_cpu_model.sv
// cpu model: apb master issuing flash bus cycles
// assumes callers pass word indices equal to flash offsets
module fcs_cpu_model #(
  parameter int ADDR_W = 14
) (
  input wire logic clk_sys,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W+2:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end
  // ==========================================================
  // one transfer; the bench watchdog bounds the wait
  // stands for a routine run from ram with every interrupt masked, so its own
  // transfers are the only traffic the flash sees during an operation
  task automatic xfer(input logic w, input logic [3:0] be, input logic [ADDR_W:0] idx,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    pstrb <= be;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : fcs_cpu_model

// ===== sim/test_fcs_flash_seq.sv
// bench for the flash sequencer: erase, program, protect, id mode, boot map
// assumes the package constants and shortened erase counts
module test_fcs_flash_seq
  import fcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AW = 14;
  localparam int SCYC = 5000;
  localparam int CCYC = 9000;
  // id codes handed to the design; values are arbitrary
  localparam logic [7:0] VEND = 8'hB4;
  localparam logic [7:0] MCODE = 8'h6D;
  localparam logic [7:0] SCODE = 8'h21;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic boot_mode = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [AW+2:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [AW-1:0] rom_a;
  wire logic [15:0] rom_d;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  assign rom_d = {2'b00, rom_a} ^ 16'hC3C3;
  fcs_flash_seq #(.ADDR_W(AW), .SECT_CYC(SCYC), .CHIP_CYC(CCYC), .VENDOR_CODE(VEND),
    .MACRO_CODE(MCODE), .SIZE_CODE(SCODE)) fcs_flash_seq_inst (
    .clk_sys(clk_sys), .rst(rst), .boot_mode(boot_mode), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boot_rom_addr(rom_a), .boot_rom_rdata(rom_d));
  fcs_cpu_model #(.ADDR_W(AW)) fcs_cpu_model_inst (
    .clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [AW:0] i, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    fcs_cpu_model_inst.xfer(1'b1, 4'hF, i, {16'h0000, d}, r, e);
  endtask : wr
  task automatic rd(input logic [AW:0] i, output logic [31:0] r, output logic e);
    fcs_cpu_model_inst.xfer(1'b0, 4'h0, i, 32'h0, r, e);
  endtask : rd
  task automatic cmd(input logic [7:0] c);
    wr({3'b000, UNLOCK1_OFS}, {8'h00, DAT_UNLOCK1});
    wr({3'b000, UNLOCK2_OFS}, {8'h00, DAT_UNLOCK2});
    wr({3'b000, UNLOCK1_OFS}, {8'h00, c});
  endtask : cmd
  task automatic rdchk(input logic [AW:0] i, input logic [15:0] x);
    logic [31:0] d;
    logic e;
    rd(i, d, e);
    chk(d, {16'h0000, x});
  endtask : rdchk
  // p7 is the expected poll bit, 8'hFF leaves it unchecked; ends at deadline dl
  task automatic poll(input logic [AW:0] i, input logic [7:0] p7, input int dl,
    input logic [15:0] x);
    logic [31:0] d, q;
    logic e;
    int n;
    repeat (3) @(posedge clk_sys);
    rd(i, d, e);
    chk(d & 32'h40, 32'h40);
    n = 0;
    while ((d & 32'hFFFF_FF3F) === 32'h0 && n < 5000) begin
      if (p7 != 8'hFF) chk(d & 32'h80, {24'h0, p7});
      q = d;
      rd(i, d, e);
      n++;
      if ((d & 32'hFFFF_FF3F) === 32'h0) chk({31'h0, d[6]}, {31'h0, ~q[6]});
    end
    chk({31'h0, cyc >= dl && cyc <= dl + 12}, 32'h1);
    rd(i, q, e);
    chk(q, d);
    chk(d, {16'h0000, x});
  endtask : poll
  // ==========================================================
  // scenarios
  task automatic erase_all();
    cmd(DAT_ERASE);
    cmd(DAT_CHIP);
    poll(15'h1234, 8'h00, cyc + CCYC, ERASED_WORD);
    rdchk(15'h0000, ERASED_WORD);
    rdchk(15'h3FFE, ERASED_WORD);
  endtask : erase_all
  task automatic program_words();
    int t0;
    cmd(DAT_PROG);
    wr(15'h0010, 16'h0706);
    t0 = cyc;
    cmd(DAT_PROG);
    wr(15'h0012, 16'h0000);
    poll(15'h0010, 8'h80, t0 + PROG_CYC, 16'h0706);
    rdchk(15'h0011, 16'h0007);
    rdchk(15'h0012, ERASED_WORD);
    cmd(DAT_PROG);
    wr(15'h2010, 16'h5AC3);
    poll(15'h2010, 8'h00, cyc + PROG_CYC, 16'h5AC3);
  endtask : program_words
  task automatic erase_sector();
    cmd(DAT_ERASE);
    wr({3'b000, UNLOCK1_OFS}, {8'h00, DAT_UNLOCK1});
    wr({3'b000, UNLOCK2_OFS}, {8'h00, DAT_UNLOCK2});
    wr(15'h0100, {8'h00, DAT_SECT});
    poll(15'h0200, 8'h00, cyc + SCYC, ERASED_WORD);
    rdchk(15'h0010, ERASED_WORD);
    rdchk(15'h2010, 16'h5AC3);
  endtask : erase_sector
  task automatic id_read(input logic [7:0] prot);
    logic [31:0] d;
    logic e;
    cmd(DAT_ID_ENTRY);
    repeat (3) @(posedge clk_sys);
    rdchk(15'h0000, {8'h00, VEND});
    rdchk(15'h0002, {8'h00, MCODE});
    rdchk(15'h0004, {8'h00, SCODE});
    rdchk(15'h0006, ID_BLANK);
    rdchk({3'b000, PROT_OFS}, {8'h00, prot});
    // an exit write with its low lane off must leave id mode in place
    fcs_cpu_model_inst.xfer(1'b1, 4'h0, 15'h0000, {24'h0, DAT_ID_EXIT}, d, e);
    rdchk(15'h0002, {8'h00, MCODE});
    wr(15'h0000, {8'h00, DAT_ID_EXIT});
    repeat (3) @(posedge clk_sys);
    rdchk(15'h2010, 16'h5AC3);
  endtask : id_read
  task automatic protect_id();
    id_read(PROT_NONE);
    cmd(DAT_PROT);
    wr({3'b000, PROT_OFS}, 16'h00F0);
    poll({3'b000, PROT_OFS}, 8'hFF, cyc + PROG_CYC, ERASED_WORD);
    id_read(8'hF0);
  endtask : protect_id
  task automatic boot_map();
    logic [31:0] d;
    logic e;
    rd(15'h4000, d, e);
    chk({31'h0, e}, 32'h1);
    rst <= 1'b1;
    boot_mode <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk(prdata, 32'h0);
    rdchk(15'h0004, 16'h0004 ^ 16'hC3C3);
    rdchk(15'h6010, 16'h5AC3);
  endtask : boot_map
  // ==========================================================
  // run control
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    erase_all();
    program_words();
    erase_sector();
    protect_id();
    boot_map();
    wrap_up();
  end
  // sized well above the sum of all auto operation times
  initial begin
    repeat (80000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
  end
endmodule : test_fcs_flash_seq
